// *** hw/otp_mode_pkg.sv ***
// Purpose: shared constants for the fuse mirror and mode controller
// Assumes: 100 MHz sys_clk
// Notes: fuse array image is one word per store, sector count fixed at two
package otp_mode_pkg;
  localparam int unsigned CFG_W = 16;               // width of one store image
  localparam int unsigned SECTORS = 2;              // sectors per store
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned INIT_TIMEOUT_S = 2;       // safety init timeout, seconds
  localparam int unsigned INIT_TIMEOUT_CYC = INIT_TIMEOUT_S * CLK_HZ;
  localparam int unsigned BURN_CYC = 16;            // cycles a burn pulse lasts
  localparam int unsigned SYNC_STAGES = 2;          // pin synchroniser depth
  localparam logic [15:0] DEBUG_LEAVE_VALUE = 16'h4000;
  localparam int unsigned DEBUG_LEAVE_POS = 14;     // bit of the debug leave flag
  localparam logic [1:0] SEC_NONE = 2'h0;
  localparam logic [1:0] SEC_FIRST = 2'h1;
  localparam logic [1:0] SEC_SECOND = 2'h2;
  typedef enum logic [2:0] {
    ST_LOAD = 3'h0,
    ST_HOLD = 3'h1,
    ST_BURN = 3'h2,
    ST_RUN = 3'h3,
    ST_DEAD = 3'h4
  } phase_t;
endpackage

// *** hw/fuse_store.sv ***
// Purpose: one fuse store of two sectors with mirror register
// Assumes: burn requests only arrive while access is allowed
// Notes: sectors written strictly first then second
`timescale 1ns/10ps
`default_nettype none
module fuse_store (
  input wire logic sys_clk, // clock
  input wire logic nrst, // async reset, low
  input wire logic load, // copy valid sector into mirror
  input wire logic wipe, // drop emulated content
  input wire logic mirror_we, // host writes mirror
  input wire logic [otp_mode_pkg::CFG_W-1:0] mirror_wdata, // mirror write data
  input wire logic burn, // burn mirror to next sector
  output logic [otp_mode_pkg::CFG_W-1:0] mirror, // mirror content
  output logic [1:0] used, // sectors programmed
  output logic valid, // mirror holds a configuration
  output logic busy // burn in progress
);
  typedef struct packed {
    logic [otp_mode_pkg::CFG_W-1:0] s1;
    logic [otp_mode_pkg::CFG_W-1:0] s2;
    logic [otp_mode_pkg::CFG_W-1:0] mir;
    logic [1:0] used;
    logic valid;
    logic [4:0] cnt;
  } st_t;
  st_t q, d;
  ////////////////////////////////////////////////////////////////
  // next state of sectors and mirror
  always_comb begin
    d = q;
    if (q.cnt != 5'h00) begin
      d.cnt = q.cnt - 5'h01;
    end
    if (load) begin
      d.valid = (q.used != otp_mode_pkg::SEC_NONE);
      d.mir = (q.used == otp_mode_pkg::SEC_SECOND) ? q.s2 :
              (q.used == otp_mode_pkg::SEC_FIRST) ? q.s1 : '0;
    end else if (wipe) begin
      d.valid = (q.used != otp_mode_pkg::SEC_NONE);
      d.mir = (q.used == otp_mode_pkg::SEC_SECOND) ? q.s2 :
              (q.used == otp_mode_pkg::SEC_FIRST) ? q.s1 : '0;
    end else if (mirror_we) begin
      d.mir = mirror_wdata;
      d.valid = 1'b1;
    end
    if (burn && q.cnt == 5'h00) begin
      if (q.used == otp_mode_pkg::SEC_NONE) begin
        d.s1 = q.mir;
        d.used = otp_mode_pkg::SEC_FIRST;
        d.cnt = 5'(otp_mode_pkg::BURN_CYC);
      end else if (q.used == otp_mode_pkg::SEC_FIRST) begin
        d.s2 = q.mir;
        d.used = otp_mode_pkg::SEC_SECOND;
        d.cnt = 5'(otp_mode_pkg::BURN_CYC);
      end
    end
  end
  // state register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign mirror = q.mir;
  assign used = q.used;
  assign valid = q.valid;
  assign busy = (q.cnt != 5'h00);
endmodule
`default_nettype wire

// *** hw/pin_sync.sv ***
// Purpose: two-stage synchroniser for a pin level
// Assumes: slow level input
// Notes: first stage read only by second
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
  input wire logic sys_clk, // clock
  input wire logic nrst, // async reset, low
  input wire logic pin, // raw pin level
  output logic level // synchronised level
);
  typedef struct packed {
    logic s1;
    logic s2;
  } st_t;
  st_t q, d;
  // shift chain
  always_comb begin
    d.s1 = pin;
    d.s2 = q.s1;
  end
  // stage registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign level = q.s2;
endmodule
`default_nettype wire

// *** hw/otp_mirror_mode_control.sv ***
// Purpose: fuse mirror loading, burning and operating mode control
// Assumes: host commands arrive as one-cycle strobes from the serial decoder
// Notes: two stores, main and fail-safe, share one mode machine
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - separate main and fail-safe fuse stores
// - each store has exactly two sectors
// - start-up loads last programmed sector
// - host fills mirror then commands burn
// - burn first sector, then second
// - after second sector no burn, emulation stays
// - fuse access only in test/OTP mode
// - emulation lost on power, deep-safe, standby
// - user mode blocks mirror and fuse access
// - debug: no windowing, timeout, safety reactions
// - normal mode windowing follows window-infinite option
// - debug pin at start enters debug+OTP
// - OTP mode always brings debug mode
// - host command leaves debug or OTP
// - test mode command needs debug pin
// - regulators off during OTP mode
// - leaving OTP starts power-up sequence
// - after OTP exit go safety init
// - configuration always taken from mirrors
// - no configuration means start fails
// - safety output low until debug left
module otp_mirror_mode_control #(
  parameter int unsigned INIT_TIMEOUT = otp_mode_pkg::INIT_TIMEOUT_CYC // safety init timeout
) (
  input wire logic sys_clk, // 100 MHz clock
  input wire logic nrst, // async reset, low
  input wire logic debug_entry_pin, // debug entry pin level
  input wire logic restart, // restart strobe
  input wire logic deep_safe_state, // deep safe state entered, strobe
  input wire logic standby, // standby entered, strobe
  input wire logic cmd_test_enter, // host: enter test mode
  input wire logic cmd_otp_exit, // host: leave OTP mode
  input wire logic failsafe_state_we, // host writes fail-safe state register
  input wire logic [15:0] failsafe_state_wdata, // data for that register
  input wire logic main_mirror_we, // host writes main mirror
  input wire logic [otp_mode_pkg::CFG_W-1:0] main_mirror_wdata, // main mirror data
  input wire logic fs_mirror_we, // host writes fail-safe mirror
  input wire logic [otp_mode_pkg::CFG_W-1:0] fs_mirror_wdata, // fail-safe mirror data
  input wire logic cmd_burn, // host: burn both mirrors
  input wire logic window_infinite_option, // fuse option, from mirror user
  input wire logic init_closed, // safety init closed by good refresh
  output logic [otp_mode_pkg::CFG_W-1:0] main_cfg, // main configuration in use
  output logic [otp_mode_pkg::CFG_W-1:0] fs_cfg, // fail-safe configuration in use
  output logic [1:0] main_used, // main sectors programmed
  output logic [1:0] fs_used, // fail-safe sectors programmed
  output logic mode_otp, // OTP mode
  output logic mode_test, // test mode
  output logic mode_debug, // debug mode
  output logic mode_user, // user mode
  output logic fuse_access, // mirror/fuse access granted
  output logic burning, // burn in progress
  output logic regulators_en, // regulators enabled
  output logic in_safety_init, // fail-safe in safety init state
  output logic init_timeout, // safety init timed out, pulse
  output logic window_en, // watchdog windowing enabled
  output logic safety_react_en, // fail-safe reactions enabled
  output logic safety_output_low, // safety output drive low
  output logic start_fail // no configuration to start with
);
  // all mode state in one record, registered as a whole
  typedef struct packed {
    otp_mode_pkg::phase_t ph;
    logic otp;
    logic test;
    logic dbg;
    logic reg_en;
    logic init;
    logic fs_low;
    logic tmo;
    logic fail;
    logic [31:0] tcnt;
    logic [1:0] settle; // synchroniser wait in LOAD
  } st_t;
  st_t q, d;

  logic dbg_lvl;
  logic load_pulse;
  logic wipe;
  logic access;
  logic burn_ok;
  logic main_valid;
  logic fs_valid;
  logic main_busy;
  logic fs_busy;
  logic restart_lvl;
  logic debug_leave;
  logic settled;
  logic burn_active;
  logic exit_req;
  logic init_counting;
  logic timeout_hit;

  ////////////////////////////////////////////////////////////////
  // pin synchronisers
  // the debug pin is a board level, so it passes two flops first
  pin_sync u_dbg_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pin(debug_entry_pin),
    .level(dbg_lvl)
  );

  // restart also arrives from outside the clock domain
  pin_sync u_rst_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pin(restart),
    .level(restart_lvl)
  );
  ////////////////////////////////////////////////////////////////
  // access gating and store control

  assign access = q.test | q.otp;

  // burn from host command
  // both stores burn together so their sector counts never drift apart
  assign burn_ok = cmd_burn & access;

  // mirrors follow the fuses for every cycle spent in LOAD
  assign load_pulse = (q.ph == otp_mode_pkg::ST_LOAD);

  assign wipe = deep_safe_state | standby;

  // debug leave bit written
  // only the flag bit is decoded; the other bits belong elsewhere
  assign debug_leave = failsafe_state_we &
                       failsafe_state_wdata[otp_mode_pkg::DEBUG_LEAVE_POS];

  fuse_store u_main (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .load(load_pulse),
    .wipe(wipe),
    .mirror_we(main_mirror_we & access),
    .mirror_wdata(main_mirror_wdata),
    .burn(burn_ok),
    .mirror(main_cfg),
    .used(main_used),
    .valid(main_valid),
    .busy(main_busy)
  );

  // fail-safe store, driven by the same load, wipe and burn
  fuse_store u_fs (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .load(load_pulse),
    .wipe(wipe),
    .mirror_we(fs_mirror_we & access),
    .mirror_wdata(fs_mirror_wdata),
    .burn(burn_ok),
    .mirror(fs_cfg),
    .used(fs_used),
    .valid(fs_valid),
    .busy(fs_busy)
  );
  ////////////////////////////////////////////////////////////////
  // decisions used by the mode machine

  // pin has passed both synchroniser stages since reset or restart
  // the count lives in the state so a restart can clear it
  assign settled = (q.settle == 2'(otp_mode_pkg::SYNC_STAGES));

  // either store still writing its fuse sector
  assign burn_active = main_busy | fs_busy;

  // OTP left by command or by pin removal
  assign exit_req = cmd_otp_exit | ~dbg_lvl;

  // timer runs in normal mode, option clear
  assign init_counting = ~q.dbg & ~window_infinite_option;

  // last counted cycle of the safety init window
  assign timeout_hit = (q.tcnt == 32'(INIT_TIMEOUT - 1));

  ////////////////////////////////////////////////////////////////
  // mode and power-up sequencing
  //
  // phases: LOAD waits for the pin synchroniser and copies the fuses,
  // HOLD is OTP mode with the regulators off, BURN keeps HOLD from
  // being left after the first busy cycle of a fuse write, RUN checks that both mirrors
  // hold an image and powers up, DEAD is the running or stuck state
  always_comb begin
    d = q;
    d.tmo = 1'b0;
    case (q.ph)

      otp_mode_pkg::ST_LOAD: begin
        // outputs stay safe while the pin is still in the synchroniser
        d.reg_en = 1'b0;
        d.init = 1'b0;
        d.fs_low = 1'b1;
        if (!settled) begin
          // the first edges after reset would read a pin as absent
          d.settle = q.settle + 2'h1;
        end else begin
          d.otp = dbg_lvl;
          d.dbg = dbg_lvl;
          d.test = dbg_lvl;
          d.ph = dbg_lvl ? otp_mode_pkg::ST_HOLD : otp_mode_pkg::ST_RUN;
        end
      end

      otp_mode_pkg::ST_HOLD: begin
        d.reg_en = 1'b0;
        if (burn_active) begin
          d.ph = otp_mode_pkg::ST_BURN;
        end
        if (exit_req) begin
          d.otp = 1'b0;
          d.ph = otp_mode_pkg::ST_RUN;
        end
      end

      otp_mode_pkg::ST_BURN: begin
        // hold off exit until the fuse write ends; a half-written
        // sector would be read back at the next start
        if (!burn_active) begin
          d.ph = otp_mode_pkg::ST_HOLD;
        end
      end

      otp_mode_pkg::ST_RUN: begin
        if (!(main_valid & fs_valid)) begin
          // regulators stay off, only a reset or restart helps
          d.fail = 1'b1;
          d.ph = otp_mode_pkg::ST_DEAD;
        end else begin
          d.reg_en = 1'b1;
          d.init = 1'b1;
          d.tcnt = '0;
          d.fail = 1'b0;
          d.ph = otp_mode_pkg::ST_DEAD;
        end
      end

      otp_mode_pkg::ST_DEAD: begin
        // running, or stuck when start failed
        if (q.init) begin
          if (init_closed) begin
            // a good refresh closes the window before the timer
            d.init = 1'b0;
          end else if (init_counting) begin
            d.tcnt = q.tcnt + 32'h00000001;
            if (timeout_hit) begin
              d.tmo = 1'b1;
              d.init = 1'b0;
            end
          end
        end
      end

      default: begin
        // unused codes fall back to a fresh start
        d.ph = otp_mode_pkg::ST_LOAD;
      end

    endcase

    if (cmd_test_enter && dbg_lvl) begin
      d.test = 1'b1;
    end

    // debug leave releases hold
    // ignored in OTP mode so the safety output cannot be released
    // while the regulators are still held off
    if (debug_leave && !d.otp) begin
      d.dbg = 1'b0;
      d.fs_low = 1'b0;
    end

    // restart rescans the pin
    // the settle count starts again so the new level is taken
    if (restart_lvl) begin
      d.ph = otp_mode_pkg::ST_LOAD;
      d.settle = '0;
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '{ph: otp_mode_pkg::ST_LOAD, fs_low: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end
  ////////////////////////////////////////////////////////////////
  // outputs
  // status levels other than window_en are decodes of flops, so they move one edge after

  // mode flags
  assign mode_otp = q.otp;
  assign mode_test = q.test | q.otp;
  assign mode_debug = q.dbg | q.otp;
  // user mode whenever no test or OTP
  assign mode_user = ~(q.test | q.otp);

  // store status seen by the host
  assign fuse_access = access;
  assign burning = burn_active;

  // power and fail-safe status
  assign regulators_en = q.reg_en & ~q.otp; // OTP wins over a stale enable
  assign in_safety_init = q.init;
  assign init_timeout = q.tmo;
  assign start_fail = q.fail;

  // debug disables windowing
  // the option is read live, so a mirror change applies at once
  assign window_en = ~(q.dbg | q.otp) & ~window_infinite_option;
  assign safety_react_en = ~(q.dbg | q.otp);

  assign safety_output_low = q.fs_low;
endmodule
`default_nettype wire

// *** test/otp_mirror_mode_control_asserts.sv ***
// Purpose: port checks for fuse burning and mode control
// Assumes: bound onto otp_mirror_mode_control
// Notes: one clock domain, so default clocking and disable
`timescale 1ns/10ps
`default_nettype none
module otp_mirror_mode_control_asserts #(
  parameter int unsigned INIT_TIMEOUT = 50 // safety init timeout
) (
  input wire logic sys_clk, // clock
  input wire logic nrst, // reset, low
  input wire logic cmd_burn, // burn strobe
  input wire logic main_mirror_we, // mirror write
  input wire logic failsafe_state_we, // state write
  input wire logic [15:0] failsafe_state_wdata, // state data
  input wire logic window_infinite_option, // fuse option
  input wire logic [otp_mode_pkg::CFG_W-1:0] main_cfg, // main config
  input wire logic [1:0] main_used, // main sectors
  input wire logic [1:0] fs_used, // fs sectors
  input wire logic mode_otp, // otp mode
  input wire logic mode_test, // test mode
  input wire logic mode_debug, // debug mode
  input wire logic mode_user, // user mode
  input wire logic fuse_access, // access granted
  input wire logic burning, // burn active
  input wire logic regulators_en, // regulators on
  input wire logic window_en, // windowing on
  input wire logic safety_react_en, // reactions on
  input wire logic safety_output_low // safety pin low
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////
  // mode relations
  AST_OTP_DEBUG: assert property (mode_otp |-> mode_debug)
    else $error("otp mode without debug mode");
  AST_OTP_TEST: assert property (mode_otp |-> mode_test && fuse_access)
    else $error("otp mode without test access");
  AST_OTP_REGS: assert property (mode_otp |-> !regulators_en)
    else $error("regulators on in otp mode");
  AST_USER_LOCK: assert property (main_mirror_we && mode_user |=> $stable(main_cfg))
    else $error("mirror written in user mode");
  AST_DEBUG_QUIET: assert property (mode_debug |-> !window_en && !safety_react_en)
    else $error("debug mode left windowing on");
  AST_NORMAL_WIN: assert property (!mode_debug && regulators_en |->
    window_en == !window_infinite_option) else $error("windowing ignores option");
  AST_SAFE_HOLD: assert property (mode_debug |-> safety_output_low)
    else $error("safety output released in debug");
  AST_DEBUG_LEAVE: assert property (failsafe_state_we && failsafe_state_wdata == 16'h4000
    && mode_debug && !mode_otp |=> !mode_debug && !safety_output_low)
    else $error("debug leave write ignored");
  ////////////////////////////////////////////////////////////////
  // burn sequencing; full stores must not move
  AST_BURN_STEP: assert property (cmd_burn && fuse_access && !burning && main_used != 2'h2
    |=> burning && main_used == $past(main_used) + 2'h1) else $error("burn did not advance");
  AST_BURN_LEN: assert property ($rose(burning) |-> ##15 burning ##1 !burning)
    else $error("burn length wrong");
  AST_BURN_FULL: assert property (cmd_burn && main_used == 2'h2 && fs_used == 2'h2
    |=> main_used == 2'h2 && !$rose(burning) && $stable(main_cfg)) else $error("burn when full");
  C_BURN: cover property ($rose(burning));
  C_LEAVE: cover property ($fell(mode_debug));
  C_FULL: cover property (cmd_burn && main_used == 2'h2);
endmodule
bind otp_mirror_mode_control otp_mirror_mode_control_asserts #(.INIT_TIMEOUT(INIT_TIMEOUT))
  u_otp_mirror_mode_control_asserts (.sys_clk, .nrst, .cmd_burn, .main_mirror_we,
  .failsafe_state_we, .failsafe_state_wdata, .window_infinite_option, .main_cfg, .main_used,
  .fs_used, .mode_otp, .mode_test, .mode_debug, .mode_user, .fuse_access, .burning,
  .regulators_en, .window_en, .safety_react_en, .safety_output_low);
`default_nettype wire

// *** test/host_model.sv ***
// Purpose: host controller turning requests into command strobes
// Assumes: go lasts one clock, set at a falling edge
// Notes: op 1 test, 2 otp exit, 3 burn, 4 state, 5 main, 6 fs mirror
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic go, // request active
  input wire logic [2:0] op, // request kind
  input wire logic [15:0] data, // request data
  output logic cmd_test_enter, // test entry
  output logic cmd_otp_exit, // otp exit
  output logic cmd_burn, // burn
  output logic failsafe_state_we, // state write
  output logic [15:0] failsafe_state_wdata, // state data
  output logic main_mirror_we, // main mirror write
  output logic [15:0] main_mirror_wdata, // main data
  output logic fs_mirror_we, // fs mirror write
  output logic [15:0] fs_mirror_wdata // fs data
);
  logic [15:0] bus_d;
  // idle data lines flip so stale values cannot pass
  assign bus_d = go ? data : ~data;
  assign failsafe_state_wdata = bus_d;
  assign main_mirror_wdata = bus_d;
  assign fs_mirror_wdata = bus_d;
  assign cmd_test_enter = go && (op == 3'h1);
  assign cmd_otp_exit = go && (op == 3'h2);
  assign cmd_burn = go && (op == 3'h3);
  assign main_mirror_we = go && (op == 3'h5);
  assign fs_mirror_we = go && (op == 3'h6);
  assign failsafe_state_we = go && (op == 3'h4);
endmodule
`default_nettype wire

// *** test/otp_mirror_mode_control_tb.sv ***
// Purpose: sequence test of fuse burn, emulation and modes
// Assumes: fuses blank after each reset
// Notes: init timeout shortened to 50 cycles
`timescale 1ns/10ps
`default_nettype none
module otp_mirror_mode_control_tb;
  logic sys_clk, nrst, debug_entry_pin, restart, deep_safe_state, standby, go;
  logic window_infinite_option, init_closed, cmd_test_enter, cmd_otp_exit, cmd_burn;
  logic failsafe_state_we, main_mirror_we, fs_mirror_we, mode_otp, mode_test, mode_debug;
  logic mode_user, fuse_access, burning, regulators_en, in_safety_init, init_timeout;
  logic window_en, safety_react_en, safety_output_low, start_fail;
  logic [2:0] op;
  logic [15:0] data, failsafe_state_wdata, main_mirror_wdata, fs_mirror_wdata, main_cfg, fs_cfg;
  logic [1:0] main_used, fs_used;
  int fail_count, n_checks, i;
  otp_mirror_mode_control #(.INIT_TIMEOUT(50)) u_otp_mirror_mode_control (.sys_clk, .nrst,
    .debug_entry_pin, .restart, .deep_safe_state, .standby, .cmd_test_enter, .cmd_otp_exit,
    .failsafe_state_we, .failsafe_state_wdata, .main_mirror_we, .main_mirror_wdata,
    .fs_mirror_we, .fs_mirror_wdata, .cmd_burn, .window_infinite_option, .init_closed,
    .main_cfg, .fs_cfg, .main_used, .fs_used, .mode_otp, .mode_test, .mode_debug, .mode_user,
    .fuse_access, .burning, .regulators_en, .in_safety_init, .init_timeout, .window_en,
    .safety_react_en, .safety_output_low, .start_fail);
  host_model u_host_model (.go, .op, .data, .cmd_test_enter, .cmd_otp_exit, .cmd_burn,
    .failsafe_state_we, .failsafe_state_wdata, .main_mirror_we, .main_mirror_wdata,
    .fs_mirror_we, .fs_mirror_wdata);
  ////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    finish_test();
  end
  ////////////////////////////////////////////////////////////////
  // one request, one clock wide, then settle
  task automatic host(input logic [2:0] o, input logic [15:0] d);
    @(negedge sys_clk);
    op = o;
    data = d;
    go = 1'b1;
    @(negedge sys_clk);
    go = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // pin set during reset; the design waits out its synchroniser
  task automatic do_reset(input logic pin);
    nrst = 1'b0;
    debug_entry_pin = pin;
    repeat (5) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (8) @(negedge sys_clk);
  endtask
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {nrst, debug_entry_pin, restart, deep_safe_state, standby, go} = '0;
    {window_infinite_option, init_closed, op, data, fail_count, n_checks} = '0;
    do_reset(1'b1);
    chk(mode_otp, 1'b1);
    chk(mode_debug, 1'b1);
    chk(fuse_access, 1'b1);
    chk(regulators_en, 1'b0);
    $display("test otp_entry done");
    host(3'h5, 16'h1234);
    host(3'h6, 16'hABCD);
    chk(main_cfg, 16'h1234);
    chk(fs_cfg, 16'hABCD);
    host(3'h3, 16'h0000);
    chk(burning, 1'b1);
    chk(main_used, 2'h1);
    chk(fs_used, 2'h1);
    repeat (20) @(negedge sys_clk);
    host(3'h5, 16'h5678);
    host(3'h3, 16'h0000);
    repeat (20) @(negedge sys_clk);
    chk(main_used, 2'h2);
    chk(fs_used, 2'h2);
    host(3'h5, 16'h9999);
    chk(main_cfg, 16'h9999);
    host(3'h3, 16'h0000);
    chk(burning, 1'b0);
    chk(main_used, 2'h2);
    chk(main_cfg, 16'h9999);
    $display("test burn done");
    host(3'h4, 16'h4000);
    chk(mode_debug, 1'b1);
    host(3'h2, 16'h0000);
    repeat (3) @(negedge sys_clk);
    chk(mode_otp, 1'b0);
    chk(regulators_en, 1'b1);
    chk(in_safety_init, 1'b1);
    chk(window_en, 1'b0);
    chk(safety_react_en, 1'b0);
    chk(safety_output_low, 1'b1);
    chk(main_cfg, 16'h9999);
    host(3'h4, 16'h4000);
    chk(mode_debug, 1'b0);
    chk(safety_output_low, 1'b0);
    chk(window_en, 1'b1);
    for (i = 0; i < 200 && init_timeout !== 1'b1; i++) @(negedge sys_clk);
    chk(init_timeout, 1'b1);
    window_infinite_option = 1'b1;
    @(negedge sys_clk);
    chk(window_en, 1'b0);
    deep_safe_state = 1'b1;
    @(negedge sys_clk);
    deep_safe_state = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(main_cfg, 16'h5678);
    chk(fs_cfg, 16'hABCD);
    $display("test otp_exit done");
    do_reset(1'b0);
    chk(mode_user, 1'b1);
    chk(start_fail, 1'b1);
    chk(regulators_en, 1'b0);
    host(3'h5, 16'h00F0);
    chk(main_cfg, 16'h0000);
    host(3'h1, 16'h0000);
    chk(mode_test, 1'b0);
    debug_entry_pin = 1'b1;
    repeat (3) @(negedge sys_clk);
    host(3'h1, 16'h0000);
    chk(mode_test, 1'b1);
    host(3'h5, 16'h00F0);
    chk(main_cfg, 16'h00F0);
    standby = 1'b1;
    @(negedge sys_clk);
    standby = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(main_cfg, 16'h0000);
    $display("test user_test done");
    // restart with the pin up re-enters OTP; filled mirrors then start
    restart = 1'b1;
    @(negedge sys_clk);
    restart = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk(mode_otp, 1'b1);
    chk(regulators_en, 1'b0);
    host(3'h5, 16'h0AAA);
    host(3'h6, 16'h0BBB);
    host(3'h2, 16'h0000);
    chk(start_fail, 1'b0);
    chk(regulators_en, 1'b1);
    chk(main_cfg, 16'h0AAA);
    repeat (60) @(negedge sys_clk);
    chk(in_safety_init, 1'b1);
    init_closed = 1'b1;
    @(negedge sys_clk);
    init_closed = 1'b0;
    chk(in_safety_init, 1'b0);
    $display("test restart done");
    finish_test();
  end
endmodule
`default_nettype wire
